// ===== logic/fgw_gateway.sv
// module: two-fieldbus slave gateway with shared process image and status word
// Behaviour
// RULE_01: slave toward both field masters, bridging data.
// RULE_02: copy process data between sides each cycle.
// RULE_03: choose version, stations, cycles automatically from data.
// RULE_04: minimize setting picks target; manual values override.
// RULE_05: version one or two, by configured data amount.
// RULE_06: protocol setting forces version two.
// RULE_07: version two carries eightfold capacity.
// RULE_08: invalid flag: zero valid, one invalid.
// RULE_09: cycle counter increments, wraps after three.
// RULE_10: status bits for more/fewer register words.
// RULE_11: status bits for more/fewer output/input bits.
// RULE_12: status 0x0100 flags invalid station address.
// RULE_13: status 0x0200 flags protocol conflict.
// RULE_14: more/fewer bits informational; exchange continues.
// RULE_15: status sent cyclically with input data.
// RULE_16: new composition applies only after restart.
// RULE_17: assignment modes affect bit data only.
// RULE_18: master may add byte entries in byte mode.
// RULE_19: map modes: bit entries, multiple of eight.
// RULE_20: master keeps bit data within stated limits.
// RULE_21: master uses only word, byte, bit entries.
// RULE_22: all configuration from the control-network side.
// RULE_23: simultaneous status conditions OR together.
// RULE_24: cycle counter two bits, resets to zero.
`timescale 1ns/1ps
`default_nettype none
module fgw_gateway (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [fgw_pkg::ADDR_W-1:0]    awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [fgw_pkg::ADDR_W-1:0]    araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    input  wire logic                          ecat_cycle,
    input  wire logic                          ecat_restart,
    input  wire fgw_pkg::fgw_wr_t              ecat_wr,
    input  wire logic [fgw_pkg::IMG_AW-1:0]    ecat_rd_addr,
    output logic [fgw_pkg::WORD_W-1:0]         ecat_rd_data,
    input  wire fgw_pkg::fgw_wr_t              ccl_wr,
    input  wire logic [fgw_pkg::IMG_AW-1:0]    ccl_rd_addr,
    output logic [fgw_pkg::WORD_W-1:0]         ccl_rd_data,
    input  wire logic                          ccl_link_ok,
    output logic [15:0]                        status_word,
    output logic                               input_object_invalid_flag,
    output logic [1:0]                         input_cycle_counter,
    output logic                               ccl_version,
    output logic [2:0]                         occupied_stations,
    output logic [2:0]                         extended_cycles
);
    import fgw_pkg::*;

    fgw_state_t r;
    fgw_state_t next;
    fgw_size_t  size_now;

    // aligned and inside the map
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a <= OFF_INFO);
    endfunction

    // writable configuration words sit below the read-only ones
    function automatic logic is_rw(input logic [ADDR_W-1:0] a);
        return addr_ok(a) && (a < OFF_STATUS);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i])
                v[i*8 +: 8] = d[i*8 +: 8];
        end
        return v;
    endfunction

    function automatic fgw_cfg_t cfg_of(input logic [RW_REGS-1:0][31:0] g);
        fgw_cfg_t c;
        c.occ         = g[IDX_CTRL][CTRL_OCC_LSB +: $bits(c.occ)];
        c.ext         = g[IDX_CTRL][CTRL_EXT_LSB +: $bits(c.ext)];
        c.minimize    = g[IDX_CTRL][CTRL_MIN_BIT];
        c.force_v2    = g[IDX_CTRL][CTRL_V2_BIT];
        c.asg         = g[IDX_CTRL][CTRL_ASG_LSB +: $bits(c.asg)];
        c.station     = g[IDX_STATION][$bits(c.station)-1:0];
        c.wr_words    = g[IDX_WORDS][$bits(c.wr_words)-1:0];
        c.rd_words    = g[IDX_WORDS][PAIR_HI_LSB +: $bits(c.rd_words)];
        c.out_entries = g[IDX_BITS][$bits(c.out_entries)-1:0];
        c.in_entries  = g[IDX_BITS][PAIR_HI_LSB +: $bits(c.in_entries)];
        return c;
    endfunction

    // each condition owns one bit, so coincident conditions simply OR together
    function automatic logic [15:0] status_of(input fgw_cfg_t c, input fgw_size_t z);
        logic [15:0] st;
        logic [10:0] ob;
        logic [10:0] ib;
        st = '0;
        ob = eff_bits(c.asg, c.out_entries);
        ib = eff_bits(c.asg, c.in_entries);
        st[ST_WR_MORE]  = c.wr_words > z.word_cap; // RULE_10 RULE_23
        st[ST_WR_FEW]   = c.wr_words < z.word_cap;
        st[ST_RD_MORE]  = c.rd_words > z.word_cap;
        st[ST_RD_FEW]   = c.rd_words < z.word_cap;
        st[ST_OUT_MORE] = ob > z.bit_cap; // RULE_11
        st[ST_OUT_FEW]  = ob < z.bit_cap;
        st[ST_IN_MORE]  = ib > z.bit_cap;
        st[ST_IN_FEW]   = ib < z.bit_cap;
        st[ST_STN_BAD]  = (c.station < STN_MIN) || (c.station > STN_MAX)
                          || (c.station + 16'(z.stations) - STN_MIN > STN_MAX); // RULE_12
        // a forced second version cannot run on single cycles here
        st[ST_PROT]     = c.force_v2 && (c.ext == EXT_SINGLE); // RULE_13
        return st;
    endfunction

    fgw_sizer u_sizer (
        .cfg  (r.cfg_live),
        .size (size_now)
    );

    // one write and one read in flight; a held response blocks the next request
    assign awready = !r.aw_got && !r.bvalid;
    assign wready  = !r.w_got && !r.bvalid;
    assign arready = !r.rvalid;

    always_comb begin
        logic [31:0] info;
        info = '0;
        next = r;
        // configuration is only ever written from the register side
        if (awvalid && awready) begin // RULE_22
            next.aw_got = 1'b1;
            next.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            next.w_got = 1'b1;
            next.wdata = wdata;
            next.wstrb = wstrb;
        end
        if (r.aw_got && r.w_got) begin
            next.aw_got = 1'b0;
            next.w_got  = 1'b0;
            next.bvalid = 1'b1;
            next.bresp  = RESP_SLVERR;
            if (is_rw(r.awaddr)) begin
                next.regs[r.awaddr[3:2]] = merge(r.regs[r.awaddr[3:2]], r.wdata, r.wstrb);
                next.bresp = RESP_OKAY;
            end
        end
        if (r.bvalid && bready)
            next.bvalid = 1'b0;
        info[INFO_VER_BIT] = r.size.version;
        info[INFO_STN_LSB +: $bits(r.size.stations)] = r.size.stations;
        info[INFO_EXT_LSB +: $bits(r.size.ext)] = r.size.ext;
        info[INFO_CNT_LSB +: $bits(r.cyc_cnt)] = r.cyc_cnt;
        info[INFO_INV_BIT] = r.invalid;
        if (arvalid && arready) begin
            next.rvalid = 1'b1;
            next.rresp  = RESP_OKAY;
            next.rdata  = '0;
            if (is_rw(araddr))
                next.rdata = r.regs[araddr[3:2]];
            else if (araddr == OFF_STATUS)
                next.rdata = {16'h0000, r.status};
            else if (araddr == OFF_INFO)
                next.rdata = info;
            else
                next.rresp = RESP_SLVERR;
        end else if (r.rvalid && rready) begin
            next.rvalid = 1'b0;
        end
        // each side writes its own staging image and reads the other side's live image
        if (ecat_wr.en)
            next.e2c_stage[ecat_wr.addr] = ecat_wr.data; // RULE_01
        if (ccl_wr.en)
            next.c2e_stage[ccl_wr.addr] = ccl_wr.data;
        next.ecat_rd_data = r.c2e_live[ecat_rd_addr];
        next.ccl_rd_data  = r.e2c_live[ccl_rd_addr];
        // copy runs whatever the status shows; more/fewer bits never stop it
        if (ecat_cycle) begin // RULE_02 RULE_14
            next.e2c_live = r.e2c_stage;
            next.c2e_live = r.c2e_stage;
            next.cyc_cnt  = (r.cyc_cnt == CNT_MAX) ? 2'h0 : r.cyc_cnt + 2'h1; // RULE_09
            next.invalid  = !r.link_ok; // RULE_08
        end
        // staged settings take effect only here, never while running
        if (ecat_restart) begin // RULE_16
            next.cfg_live = cfg_of(r.regs);
            next.invalid  = INVALID_RST;
        end
        next.size   = size_now;
        next.status = status_of(r.cfg_live, size_now); // RULE_15
        // pin sampled by three flops; level moves only when the last two agree
        next.link_sync = {r.link_sync[1:0], ccl_link_ok};
        if (r.link_sync[1] == r.link_sync[2])
            next.link_ok = r.link_sync[2];
        if (!aresetn) begin
            next = '0; // RULE_24
            next.invalid = INVALID_RST;
            next.size.stations = STN_RST;
            next.size.ext = EXT_RST;
        end
    end

    always_ff @(posedge aclk) begin
        r <= next;
    end

    assign bresp                     = r.bresp;
    assign bvalid                    = r.bvalid;
    assign rdata                     = r.rdata;
    assign rresp                     = r.rresp;
    assign rvalid                    = r.rvalid;
    assign ecat_rd_data              = r.ecat_rd_data;
    assign ccl_rd_data               = r.ccl_rd_data;
    assign status_word               = r.status;
    assign input_object_invalid_flag = r.invalid;
    assign input_cycle_counter       = r.cyc_cnt;
    assign ccl_version               = r.size.version;
    assign occupied_stations         = r.size.stations;
    assign extended_cycles           = r.size.ext;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence cycle_s;
        ecat_cycle && !ecat_restart;
    endsequence

    sequence wrap_s;
        cycle_s ##0 (r.cyc_cnt == CNT_MAX);
    endsequence

    sequence write_pair_s;
        r.aw_got && r.w_got;
    endsequence

    cnt_wrap_a: assert property (wrap_s |=> input_cycle_counter == 2'h0) // RULE_09
        else $error("cycle counter did not wrap to zero");
    cnt_step_a: assert property (cycle_s ##0 (r.cyc_cnt != CNT_MAX)
        |=> input_cycle_counter == $past(r.cyc_cnt) + 2'h1) // RULE_09
        else $error("cycle counter did not step by one");
    cnt_idle_a: assert property (!ecat_cycle |=> $stable(input_cycle_counter)) // RULE_24
        else $error("cycle counter moved without a cycle");
    cfg_latch_a: assert property (ecat_restart |=> r.cfg_live == cfg_of($past(r.regs))) // RULE_16
        else $error("restart did not apply staged settings");
    cfg_hold_a: assert property (!ecat_restart |=> $stable(r.cfg_live)) // RULE_16
        else $error("live settings changed while running");
    img_copy_a: assert property (ecat_cycle |=> (r.c2e_live == $past(r.c2e_stage))
        && (r.e2c_live == $past(r.e2c_stage))) // RULE_02
        else $error("process image not copied on cycle");
    invalid_flag_a: assert property (cycle_s |=>
        input_object_invalid_flag == !$past(r.link_ok)) // RULE_08
        else $error("invalid flag does not follow link state");
    station_bad_a: assert property ((r.cfg_live.station < STN_MIN
        || r.cfg_live.station > STN_MAX) |=> status_word[ST_STN_BAD]) // RULE_12
        else $error("bad station address not reported");
    force_v2_a: assert property (r.cfg_live.force_v2 |-> size_now.version) // RULE_06
        else $error("forced second version not presented");
    manual_stn_a: assert property ((r.cfg_live.occ != 3'h0 && r.cfg_live.occ <= MAX_STN)
        |-> size_now.stations == r.cfg_live.occ) // RULE_04
        else $error("manual station count not honoured");
    octuple_cap_a: assert property (size_now.ext == MAX_EXT |-> size_now.word_cap
        == 8'(cap_words(size_now.stations, EXT_SINGLE) * V2_FACTOR)) // RULE_07
        else $error("octuple capacity is not eightfold");
    write_resp_a: assert property (write_pair_s |=> bvalid ##0 (bresp // RULE_22
        == (is_rw($past(r.awaddr)) ? RESP_OKAY : RESP_SLVERR)))
        else $error("write response missing or wrong");
endmodule
`default_nettype wire

// ===== pkg/fgw_pkg.sv
// package: register map, constants and carrier types of the fieldbus gateway
package fgw_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          WORD_W        = 16;
    localparam int          IMG_DEPTH     = 8;
    localparam int          IMG_AW        = 3;
    localparam int          RW_REGS       = 4;

    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATION   = 8'h04;
    localparam logic [7:0]  OFF_WORDS     = 8'h08;
    localparam logic [7:0]  OFF_BITS      = 8'h0c;
    localparam logic [7:0]  OFF_STATUS    = 8'h10;
    localparam logic [7:0]  OFF_INFO      = 8'h14;
    localparam int          IDX_CTRL      = int'(OFF_CTRL[3:2]);
    localparam int          IDX_STATION   = int'(OFF_STATION[3:2]);
    localparam int          IDX_WORDS     = int'(OFF_WORDS[3:2]);
    localparam int          IDX_BITS      = int'(OFF_BITS[3:2]);

    localparam int          CTRL_OCC_LSB  = 0;
    localparam int          CTRL_EXT_LSB  = 4;
    localparam int          CTRL_MIN_BIT  = 8;
    localparam int          CTRL_V2_BIT   = 9;
    localparam int          CTRL_ASG_LSB  = 12;
    localparam int          PAIR_HI_LSB   = 8;
    localparam int          INFO_VER_BIT  = 0;
    localparam int          INFO_STN_LSB  = 4;
    localparam int          INFO_EXT_LSB  = 8;
    localparam int          INFO_CNT_LSB  = 12;
    localparam int          INFO_INV_BIT  = 16;

    localparam int          ST_WR_MORE    = 0;
    localparam int          ST_WR_FEW     = 1;
    localparam int          ST_RD_MORE    = 2;
    localparam int          ST_RD_FEW     = 3;
    localparam int          ST_OUT_MORE   = 4;
    localparam int          ST_OUT_FEW    = 5;
    localparam int          ST_IN_MORE    = 6;
    localparam int          ST_IN_FEW     = 7;
    localparam int          ST_STN_BAD    = 8;
    localparam int          ST_PROT       = 9;

    localparam logic [2:0]  ASG_BYTE      = 3'h1;
    localparam logic [2:0]  ASG_MAP1      = 3'h2;
    localparam logic [2:0]  ASG_MAP4      = 3'h5;
    localparam logic [10:0] BITS_PER_BYTE = 11'h008;
    localparam logic [10:0] BITS_PER_STN  = 11'h020;
    localparam logic [7:0]  WORDS_PER_STN = 8'h04;
    localparam logic [7:0]  V2_FACTOR     = 8'h08;
    localparam logic [2:0]  MAX_STN       = 3'h4;
    localparam logic [2:0]  MAX_EXT       = 3'h4;
    localparam logic [2:0]  EXT_SINGLE    = 3'h1;
    localparam logic [15:0] STN_MIN       = 16'h0001;
    localparam logic [15:0] STN_MAX       = 16'h0040;
    localparam logic [1:0]  CNT_MAX       = 2'h3;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic        INVALID_RST   = 1'b1;
    localparam logic [2:0]  STN_RST       = 3'h1;
    localparam logic [2:0]  EXT_RST       = 3'h1;

    typedef struct packed {
        logic [15:0] station;
        logic [2:0]  occ;
        logic [2:0]  ext;
        logic        minimize;
        logic        force_v2;
        logic [2:0]  asg;
        logic [7:0]  wr_words;
        logic [7:0]  rd_words;
        logic [7:0]  out_entries;
        logic [7:0]  in_entries;
    } fgw_cfg_t;

    typedef struct packed {
        logic        version;
        logic [2:0]  stations;
        logic [2:0]  ext;
        logic [10:0] bit_cap;
        logic [7:0]  word_cap;
    } fgw_size_t;

    typedef struct packed {
        logic              en;
        logic [IMG_AW-1:0] addr;
        logic [WORD_W-1:0] data;
    } fgw_wr_t;

    typedef struct packed {
        logic [RW_REGS-1:0][31:0]          regs;
        fgw_cfg_t                          cfg_live;
        fgw_size_t                         size;
        logic [15:0]                       status;
        logic [1:0]                        cyc_cnt;
        logic                              invalid;
        logic [2:0]                        link_sync;
        logic                              link_ok;
        logic [IMG_DEPTH-1:0][WORD_W-1:0]  e2c_stage;
        logic [IMG_DEPTH-1:0][WORD_W-1:0]  e2c_live;
        logic [IMG_DEPTH-1:0][WORD_W-1:0]  c2e_stage;
        logic [IMG_DEPTH-1:0][WORD_W-1:0]  c2e_live;
        logic [WORD_W-1:0]                 ecat_rd_data;
        logic [WORD_W-1:0]                 ccl_rd_data;
        logic                              aw_got;
        logic                              w_got;
        logic [ADDR_W-1:0]                 awaddr;
        logic [31:0]                       wdata;
        logic [3:0]                        wstrb;
        logic                              bvalid;
        logic [1:0]                        bresp;
        logic                              rvalid;
        logic [31:0]                       rdata;
        logic [1:0]                        rresp;
    } fgw_state_t;

    // bit count that a number of bit entries stands for under an assignment mode
    function automatic logic [10:0] eff_bits(input logic [2:0] asg, input logic [7:0] n);
        logic [10:0] e;
        e = {3'h0, n};
        if (asg == ASG_BYTE)
            e = e * BITS_PER_BYTE;
        else if (asg >= ASG_MAP1 && asg <= ASG_MAP4)
            e = e * 11'(asg - ASG_MAP1 + 3'h1);
        return e;
    endfunction

    function automatic logic [10:0] cap_bits(input logic [2:0] s, input logic [2:0] m);
        return (BITS_PER_STN * 11'(s)) << (m - 3'h1);
    endfunction

    function automatic logic [7:0] cap_words(input logic [2:0] s, input logic [2:0] m);
        return (WORDS_PER_STN * 8'(s)) << (m - 3'h1);
    endfunction
endpackage

// ===== logic/fgw_sizer.sv
// module: automatic choice of link version, occupied stations and extended cycles
`timescale 1ns/1ps
`default_nettype none
module fgw_sizer (
    input  wire fgw_pkg::fgw_cfg_t  cfg,
    output var  fgw_pkg::fgw_size_t size
);
    import fgw_pkg::*;

    always_comb begin
        logic        found;
        logic [2:0]  s;
        logic [2:0]  m;
        logic [2:0]  ts;
        logic [2:0]  tm;
        logic [10:0] need_bits;
        logic [7:0]  need_words;
        found = 1'b0;
        s = MAX_STN;
        m = MAX_EXT;
        ts = MAX_STN;
        tm = MAX_EXT;
        // remote register words never scale with the assignment mode
        need_words = (cfg.wr_words > cfg.rd_words) ? cfg.wr_words : cfg.rd_words; // RULE_17
        need_bits = eff_bits(cfg.asg, cfg.out_entries);
        if (eff_bits(cfg.asg, cfg.in_entries) > need_bits)
            need_bits = eff_bits(cfg.asg, cfg.in_entries);
        // manual values override; out of range values fall back to the maximum
        if (cfg.occ != 3'h0 && cfg.occ <= MAX_STN) begin
            s = cfg.occ; // RULE_04
        end
        if (cfg.ext != 3'h0 && cfg.ext <= MAX_EXT) begin
            m = cfg.ext; // RULE_04
        end
        // outer loop walks the quantity being minimised, so the first fit is the smallest
        for (int a = 1; a <= int'(MAX_STN); a++) begin
            for (int b = 1; b <= int'(MAX_EXT); b++) begin
                ts = cfg.minimize ? 3'(a) : 3'(b); // RULE_04
                tm = cfg.minimize ? 3'(b) : 3'(a);
                if (!found && (cfg.occ == 3'h0 || cfg.occ == ts)
                    && (cfg.ext == 3'h0 || cfg.ext == tm)
                    && cap_bits(ts, tm) >= need_bits
                    && cap_words(ts, tm) >= need_words) begin // RULE_03
                    found = 1'b1;
                    s = ts;
                    m = tm;
                end
            end
        end
        size.stations = s;
        size.ext      = m;
        // extended cycles up to octuple give the eightfold capacity of the second version
        size.version  = (m != EXT_SINGLE) || cfg.force_v2; // RULE_05 RULE_06
        size.bit_cap  = cap_bits(s, m); // RULE_07
        size.word_cap = cap_words(s, m);
    end
endmodule
`default_nettype wire

// ===== verif/fgw_ccl_master.sv
// far-side field master model: writes its image and reports link state
`timescale 1ns/1ps
`default_nettype none
module fgw_ccl_master (
    input  wire logic            aclk,
    output var  fgw_pkg::fgw_wr_t wr,
    output var  logic            link_ok
);
    import fgw_pkg::*;
    initial begin
        wr = '0;
        link_ok = 1'h0;
    end
    task automatic link(input logic v);
        @(posedge aclk);
        link_ok <= v;
    endtask
    // only exchanges data, never sets the gateway up
    task automatic put(input logic [IMG_AW-1:0] a, input logic [WORD_W-1:0] d);
        @(posedge aclk);
        wr <= '{1'h1, a, d};
        @(posedge aclk);
        // released lines must not keep the last value
        wr <= '{1'h0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ===== verif/fieldbus_gateway_process_image_tb.sv
// self-checking bench for the fieldbus gateway
`timescale 1ns/1ps
`default_nettype none
module fieldbus_gateway_process_image_tb;
    import fgw_pkg::*;
    // response ready lines stay high: every answer is taken at the edge it shows
    logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
    logic        arvalid = 1'h0, rready = 1'h1, ecat_cycle = 1'h0, ecat_restart = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, ccl_link_ok, inv, ver;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, cnt, c0;
    logic [2:0]  ecat_rd_addr = '0, ccl_rd_addr = '0, stn, ext;
    logic [15:0] ecat_rd_data, ccl_rd_data, status, old, d;
    fgw_wr_t     ecat_wr = '0, ccl_wr;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    int          errors = 0, check_count = 0;
    // ctrl, station, words, bits, then expected {status, version, stations, ext}
    // entries are word, byte or bit typed and stay far below the bit limit
    logic [31:0] tc[6][4] = '{'{32'h0, 32'h1, 32'h404, 32'h2020}, '{32'h0, 32'h1, 32'h405, 32'h2020},
        '{32'h100, 32'h1, 32'h405, 32'h2020}, '{32'h210, 32'h1, 32'h404, 32'h2020},
        '{32'h1000, 32'h41, 32'h404, 32'h404},
        '{32'h5000, 32'h1, 32'h404, 32'h1010}};
    logic [22:0] te[6] = '{23'h9, 23'h5511, 23'h554a, 23'h10049, 23'h8009, 23'h511};
    fgw_gateway i_fgw_gateway (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .ecat_cycle, .ecat_restart, .ecat_wr, .ecat_rd_addr, .ecat_rd_data,
        .ccl_wr, .ccl_rd_addr, .ccl_rd_data, .ccl_link_ok, .status_word(status),
        .input_object_invalid_flag(inv), .input_cycle_counter(cnt), .ccl_version(ver),
        .occupied_stations(stn), .extended_cycles(ext));
    fgw_ccl_master i_fgw_ccl_master (.aclk(aclk), .wr(ccl_wr), .link_ok(ccl_link_ok));
    always #4 aclk = ~aclk;
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // responses are matched in order against the notes left by the bus tasks
    always @(posedge aclk) begin
        if (bvalid && bready)
            chk(bresp, bq.pop_front());
        if (rvalid && rready)
            chk({rresp, rdata}, rq.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        logic ap, dp;
        ap = 1'h1;
        dp = 1'h1;
        bq.push_back(r);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (ap || dp) begin
            @(posedge aclk);
            if (awready && ap) begin
                ap = 1'h0;
                awvalid <= 1'h0;
            end
            if (wready && dp) begin
                dp = 1'h0;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
    endtask
    task automatic restart;
        ecat_restart <= 1'h1;
        @(posedge aclk);
        ecat_restart <= 1'h0;
        repeat (4) @(posedge aclk);
    endtask
    initial begin
        #160000;
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'hfbf1eb9e));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk({inv, cnt, ver, stn, ext}, 34'h209);
        repeat (2) @(posedge aclk);
        chk(status, 34'h1aa);
        rd(OFF_CTRL, 34'h0);
        rd(OFF_STATUS, {RESP_OKAY, 32'h1aa});
        rd(OFF_INFO, {RESP_OKAY, 32'h10110});
        rd(8'h18, {RESP_SLVERR, 32'h0});
        wr(OFF_STATUS, 32'h1, RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            old = status;
            wr(OFF_CTRL, tc[i][0], RESP_OKAY);
            wr(OFF_STATION, tc[i][1], RESP_OKAY);
            wr(OFF_WORDS, tc[i][2], RESP_OKAY);
            wr(OFF_BITS, tc[i][3], RESP_OKAY);
            rd(OFF_CTRL, {RESP_OKAY, tc[i][0]});
            chk(status, old);
            restart();
            chk({status, ver, stn, ext}, te[i]);
        end
        i_fgw_ccl_master.link(1'h1);
        repeat (6) @(posedge aclk);
        c0 = cnt;
        // status is nonzero here, yet data must keep flowing
        for (int k = 0; k < 4; k++) begin
            d = 16'($urandom);
            ecat_wr <= '{1'h1, 3'(k), d};
            i_fgw_ccl_master.put(3'(k), ~d);
            ecat_wr <= '0;
            ecat_cycle <= 1'h1;
            @(posedge aclk);
            ecat_cycle <= 1'h0;
            ecat_rd_addr <= 3'(k);
            ccl_rd_addr <= 3'(k);
            repeat (2) @(posedge aclk);
            chk({ccl_rd_data, ecat_rd_data}, {d, ~d});
            chk(cnt, 2'(c0 + 2'(k) + 2'h1));
            chk(inv, 1'h0);
        end
        restart();
        chk(inv, 1'h1);
        conclude();
    end
endmodule
`default_nettype wire
